// ### ctmc_pkg.sv
`default_nettype none
package ctmc_pkg;

	// ****************************************
	// timing (device clock cycles)
	// ****************************************
	localparam int unsigned CLOCK_HZ            = 10_000_000;
	localparam int unsigned DOM_TIMEOUT_CYC     = 20000;
	localparam int unsigned SILENCE_CYC         = 20000;
	localparam int unsigned BIAS_ACT_CYC        = 2000;
	localparam int unsigned PERM_DOM_CYC        = 20000;
	localparam int unsigned FAIL_FOLLOW_COUNT   = 4;
	localparam int unsigned FOLLOW_WINDOW_CYC   = 10;
	localparam int unsigned WUP_MIN_PHASE_CYC   = 5;
	localparam int unsigned WUP_MAX_GAP_CYC     = 10000;

	// ****************************************
	// levels and reset values
	// ****************************************
	localparam logic LVL_DOMINANT  = 1'b0;
	localparam logic LVL_RECESSIVE = 1'b1;

	typedef enum {
		CTMC_SLEEP,
		CTMC_BIAS,
		CTMC_READY
	} ctmc_state_t;

	typedef struct packed {
		logic transmit_path_enable;
		logic receive_path_enable;
		logic pretended_network_enable;
		logic loopback_enable;
		logic transceiver_go_ready;
		logic low_power_mode_ok;
	} ctmc_ctrl_t;

	typedef struct packed {
		logic txd_dom_flag;
		logic bus_perm_recessive_flag;
		logic bus_perm_dominant_flag;
		logic rx_line_recessive_flag;
	} ctmc_flags_t;

	localparam ctmc_flags_t FLAGS_RESET = '0;

endpackage
`default_nettype wire

// ### ctmc_wake_detect.sv
`default_nettype none
// ****************************************
// dominant-recessive-dominant wake pattern
// ****************************************
module ctmc_wake_detect #(
	parameter int unsigned MIN_PHASE = ctmc_pkg::WUP_MIN_PHASE_CYC,
	parameter int unsigned MAX_GAP   = ctmc_pkg::WUP_MAX_GAP_CYC
) (
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_arm,
	input  wire logic i_bus,
	output logic      o_wake
);
	typedef enum {
		CTMC_W_IDLE,
		CTMC_W_DOM1,
		CTMC_W_REC,
		CTMC_W_DOM2
	} ctmc_wstate_t;

	ctmc_wstate_t wst_r;
	ctmc_wstate_t wst_nxt;
	logic [15:0]  cnt_r;
	logic         is_dom;
	logic         phase_ok;
	logic         gap_over;
	logic         wake_nxt;

	assign is_dom   = (i_bus == ctmc_pkg::LVL_DOMINANT);
	assign phase_ok = (cnt_r >= 16'(MIN_PHASE));
	assign gap_over = (cnt_r >= 16'(MAX_GAP));

	// starting from idle means bus level at entry does not matter
	always_comb begin
		wst_nxt  = wst_r;
		wake_nxt = 1'b0;
		case (wst_r)
			CTMC_W_IDLE: if (is_dom) wst_nxt = CTMC_W_DOM1;
			CTMC_W_DOM1: if (!is_dom) wst_nxt = phase_ok ? CTMC_W_REC : CTMC_W_IDLE;
			CTMC_W_REC: begin
				if (is_dom) wst_nxt = phase_ok ? CTMC_W_DOM2 : CTMC_W_DOM1;
				else if (gap_over) wst_nxt = CTMC_W_IDLE;
			end
			CTMC_W_DOM2: begin
				if (phase_ok) begin
					wake_nxt = 1'b1;
					wst_nxt  = CTMC_W_IDLE;
				end else if (!is_dom) begin
					wst_nxt = CTMC_W_REC;
				end
			end
			default: wst_nxt = CTMC_W_IDLE;
		endcase
		if (!i_arm) wst_nxt = CTMC_W_IDLE;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wst_r  <= CTMC_W_IDLE;
			cnt_r  <= 16'h0000;
			o_wake <= 1'b0;
		end else begin
			wst_r  <= wst_nxt;
			cnt_r  <= (wst_nxt != wst_r) ? 16'h0000 : (gap_over ? cnt_r : cnt_r + 16'h0001);
			o_wake <= wake_nxt & i_arm;
		end
	end
endmodule
`default_nettype wire

// ### ctmc_top.sv
`default_nettype none
// How it works
// - ready: bias on, paths from enable bits
// - bias state: sleep after silence timeout
// - bias state: transmitter off, receiver per enable
// - bias wake in standby/active: interrupt, ready
// - power-on: sleep, bias off, paths off
// - sleep wake: interrupt, ready or bias
// - auto biasing in sleep state only; bias state keeps bias on
// - wake pattern: dominant, recessive, dominant
// - wake works from either entry level
// - loopback routes transmit input to receive
// - pretended networking: messages bias, interrupt, pass
// - disabled until go-ready written one
// - failures other than bus dominant disable transmitter, never receiver
// - dominant transmit timeout latches, blocks transmitter
// - four bus follow failures latch recessive
// - bus dominant too long latches flag
// - four receive follow failures latch flag
module ctmc_top #(
	parameter int unsigned DOM_TIMEOUT = ctmc_pkg::DOM_TIMEOUT_CYC,
	parameter int unsigned SILENCE     = ctmc_pkg::SILENCE_CYC,
	parameter int unsigned BIAS_ACT    = ctmc_pkg::BIAS_ACT_CYC,
	parameter int unsigned PERM_DOM    = ctmc_pkg::PERM_DOM_CYC,
	parameter int unsigned FAIL_COUNT  = ctmc_pkg::FAIL_FOLLOW_COUNT,
	parameter int unsigned FOLLOW_WIN  = ctmc_pkg::FOLLOW_WINDOW_CYC
) (
	input  wire logic                 i_clock,
	input  wire logic                 i_nrst,
	input  wire ctmc_pkg::ctmc_ctrl_t i_ctrl,
	input  wire ctmc_pkg::ctmc_flags_t i_flag_clear,
	input  wire logic                 i_thermal_shutdown_level_one,
	input  wire logic                 i_txd,
	input  wire logic                 i_bus_rx,
	output logic                      o_rxd,
	output logic                      o_bus_tx,
	output logic                      o_tx_enabled,
	output logic                      o_rx_enabled,
	output logic                      o_bias_on,
	output logic                      o_wake_irq,
	output ctmc_pkg::ctmc_state_t     o_state,
	output ctmc_pkg::ctmc_flags_t     o_flags
);
	// ****************************************
	// reset and input synchronisers
	// ****************************************
	logic [1:0] rst_sync_r;
	logic       rst_n;
	logic [1:0] txd_sync_r;
	logic [1:0] bus_sync_r;
	logic [1:0] tsd_sync_r;
	logic       txd_s;
	logic       bus_s;
	logic       tsd_s;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) rst_sync_r <= 2'b00;
		else rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			txd_sync_r <= 2'b11;
			bus_sync_r <= 2'b11;
			tsd_sync_r <= 2'b00;
		end else begin
			txd_sync_r <= {txd_sync_r[0], i_txd};
			bus_sync_r <= {bus_sync_r[0], i_bus_rx};
			tsd_sync_r <= {tsd_sync_r[0], i_thermal_shutdown_level_one};
		end
	end
	assign txd_s = txd_sync_r[1];
	assign bus_s = bus_sync_r[1];
	assign tsd_s = tsd_sync_r[1];

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic run);
		sat_inc = !run ? 16'h0000 : ((v == 16'hffff) ? v : v + 16'h0001);
	endfunction

	function automatic logic [2:0] fail_inc(input logic [2:0] v, input logic hit, input logic ok);
		fail_inc = ok ? 3'b000 : (hit ? v + 3'b001 : v);
	endfunction

	// ****************************************
	// state machine
	// ****************************************
	ctmc_pkg::ctmc_state_t st_r;
	ctmc_pkg::ctmc_state_t st_nxt;
	logic                  enabled_r;
	logic                  wake;
	logic                  low_power;
	logic                  bus_dom;
	logic                  txd_dom;
	logic [15:0]           silence_r;
	logic [15:0]           bias_act_r;
	logic                  silence_over;
	logic                  bias_r;
	logic                  bias_nxt;
	logic                  irq_nxt;
	logic                  irq_r;

	assign bus_dom   = (bus_s == ctmc_pkg::LVL_DOMINANT);
	assign txd_dom   = (txd_s == ctmc_pkg::LVL_DOMINANT);
	assign low_power = (st_r != ctmc_pkg::CTMC_READY);
	assign silence_over = (silence_r >= 16'(SILENCE));

	// disabled until software asks for ready once
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) enabled_r <= 1'b0;
		else if (i_ctrl.transceiver_go_ready) enabled_r <= 1'b1;
	end

	ctmc_wake_detect u_wake (
		.i_clock (i_clock),
		.i_rst_n (rst_n),
		.i_arm   (low_power),
		.i_bus   (bus_s),
		.o_wake  (wake)
	);

	always_comb begin
		st_nxt  = st_r;
		irq_nxt = 1'b0;
		case (st_r)
			ctmc_pkg::CTMC_SLEEP: begin
				if (wake) begin
					irq_nxt = 1'b1;
					st_nxt  = i_ctrl.pretended_network_enable ? ctmc_pkg::CTMC_BIAS : ctmc_pkg::CTMC_READY;
				end else if (i_ctrl.transceiver_go_ready) begin
					st_nxt = ctmc_pkg::CTMC_READY;
				end
			end
			ctmc_pkg::CTMC_BIAS: begin
				if (silence_over) begin
					st_nxt = ctmc_pkg::CTMC_SLEEP;
				end else if (wake && i_ctrl.low_power_mode_ok) begin
					irq_nxt = 1'b1;
					st_nxt  = ctmc_pkg::CTMC_READY;
				end else if (wake) begin
					irq_nxt = 1'b1;
				end
			end
			ctmc_pkg::CTMC_READY: st_nxt = ctmc_pkg::CTMC_READY;
			default: st_nxt = ctmc_pkg::CTMC_SLEEP;
		endcase
		if (!enabled_r && !i_ctrl.transceiver_go_ready && st_nxt == ctmc_pkg::CTMC_READY && !wake)
			st_nxt = st_r;
	end

	// ****************************************
	// automatic voltage biasing
	// ****************************************
	// bias pulled down after silence, restored once the bus has stayed dominant for the activation time in sleep
	assign bias_nxt = (st_nxt == ctmc_pkg::CTMC_READY) || (st_nxt == ctmc_pkg::CTMC_BIAS) ||
	                  (bias_act_r != 16'h0000 && bias_act_r >= 16'(BIAS_ACT));

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r       <= ctmc_pkg::CTMC_SLEEP;
			bias_r     <= 1'b0;
			silence_r  <= 16'h0000;
			bias_act_r <= 16'h0000;
			irq_r      <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			bias_r     <= bias_nxt;
			silence_r  <= sat_inc(silence_r, st_r == ctmc_pkg::CTMC_BIAS && !bus_dom);
			bias_act_r <= sat_inc(bias_act_r, st_r == ctmc_pkg::CTMC_SLEEP && bus_dom);
			irq_r      <= irq_nxt;
		end
	end

	// ****************************************
	// error detection
	// ****************************************
	ctmc_pkg::ctmc_flags_t flags_r;
	ctmc_pkg::ctmc_flags_t flags_set;
	logic [15:0] txdom_cnt_r;
	logic [15:0] busdom_cnt_r;
	logic [7:0]  follow_cnt_r;
	logic        txd_dom_d_r;
	logic        follow_pending_r;
	logic        bus_followed_r;
	logic        rx_followed_r;
	logic [2:0]  bus_fail_r;
	logic [2:0]  rx_fail_r;
	logic        follow_end;
	logic        tx_on;
	logic        rx_on;
	logic        rxd_line;

	assign follow_end = follow_pending_r && (follow_cnt_r >= 8'(FOLLOW_WIN));

	assign flags_set.txd_dom_flag            = txdom_cnt_r >= 16'(DOM_TIMEOUT);
	// set is the miss event itself, so a clear is not undone by a stale count
	assign flags_set.bus_perm_recessive_flag = follow_end && !bus_followed_r &&
	                                           (bus_fail_r >= 3'(FAIL_COUNT - 1));
	assign flags_set.bus_perm_dominant_flag  = busdom_cnt_r >= 16'(PERM_DOM);
	assign flags_set.rx_line_recessive_flag  = follow_end && !rx_followed_r &&
	                                           (rx_fail_r >= 3'(FAIL_COUNT - 1));

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			txdom_cnt_r      <= 16'h0000;
			busdom_cnt_r     <= 16'h0000;
			follow_cnt_r     <= 8'h00;
			txd_dom_d_r      <= 1'b0;
			follow_pending_r <= 1'b0;
			bus_followed_r   <= 1'b0;
			rx_followed_r    <= 1'b0;
			bus_fail_r       <= 3'b000;
			rx_fail_r        <= 3'b000;
			flags_r          <= ctmc_pkg::FLAGS_RESET;
		end else begin
			txd_dom_d_r  <= txd_dom;
			txdom_cnt_r  <= sat_inc(txdom_cnt_r, txd_dom && tx_on);
			busdom_cnt_r <= sat_inc(busdom_cnt_r, bus_dom);
			// loopback holds the bus recessive, so no follow check then
			if (txd_dom && !txd_dom_d_r && tx_on && !i_ctrl.loopback_enable) begin
				follow_pending_r <= 1'b1;
				follow_cnt_r     <= 8'h00;
				bus_followed_r   <= 1'b0;
				rx_followed_r    <= 1'b0;
			end else if (follow_pending_r) begin
				follow_cnt_r   <= follow_cnt_r + 8'h01;
				bus_followed_r <= bus_followed_r | bus_dom;
				rx_followed_r  <= rx_followed_r | (rxd_line == ctmc_pkg::LVL_DOMINANT);
				if (follow_end) follow_pending_r <= 1'b0;
			end
			bus_fail_r <= fail_inc(bus_fail_r, follow_end && !bus_followed_r, follow_end && bus_followed_r);
			rx_fail_r  <= fail_inc(rx_fail_r, follow_end && !rx_followed_r, follow_end && rx_followed_r);
			if (i_flag_clear.bus_perm_recessive_flag) bus_fail_r <= 3'b000;
			if (i_flag_clear.rx_line_recessive_flag) rx_fail_r <= 3'b000;
			// set beats clear in the same cycle
			flags_r <= (flags_r & ~i_flag_clear) | flags_set;
		end
	end

	// ****************************************
	// path control and outputs
	// ****************************************
	assign tx_on = enabled_r && (st_r == ctmc_pkg::CTMC_READY) && i_ctrl.transmit_path_enable &&
	               !flags_r.txd_dom_flag && !flags_r.bus_perm_recessive_flag &&
	               !flags_r.rx_line_recessive_flag && !tsd_s;
	// receiver never disabled by failures
	assign rx_on = enabled_r && (st_r != ctmc_pkg::CTMC_SLEEP) && i_ctrl.receive_path_enable;
	// pretended networking frames pass in bias state
	assign rxd_line = i_ctrl.loopback_enable ? txd_s :
	                  ((rx_on || (st_r == ctmc_pkg::CTMC_BIAS && i_ctrl.pretended_network_enable)) ? bus_s
	                  : ctmc_pkg::LVL_RECESSIVE);

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_rxd        <= ctmc_pkg::LVL_RECESSIVE;
			o_bus_tx     <= ctmc_pkg::LVL_RECESSIVE;
			o_tx_enabled <= 1'b0;
			o_rx_enabled <= 1'b0;
		end else begin
			o_rxd        <= rxd_line;
			o_bus_tx     <= (tx_on && !i_ctrl.loopback_enable) ? txd_s : ctmc_pkg::LVL_RECESSIVE;
			o_tx_enabled <= tx_on;
			o_rx_enabled <= rx_on;
		end
	end

	assign o_bias_on  = bias_r;
	assign o_wake_irq = irq_r;
	assign o_state    = st_r;
	assign o_flags    = flags_r;
endmodule
`default_nettype wire

// ### ctmc_chk.sv
`default_nettype none
// ****************************************
// port-level checks
// ****************************************
module ctmc_chk (
	input wire logic                  i_clock,
	input wire logic                  i_nrst,
	input wire ctmc_pkg::ctmc_ctrl_t  i_ctrl,
	input wire logic                  i_txd,
	input wire logic                  o_rxd,
	input wire logic                  o_bus_tx,
	input wire logic                  o_tx_enabled,
	input wire logic                  o_rx_enabled,
	input wire logic                  o_bias_on,
	input wire logic                  o_wake_irq,
	input var ctmc_pkg::ctmc_state_t  o_state,
	input wire ctmc_pkg::ctmc_flags_t o_flags
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	wire logic blk = o_flags.txd_dom_flag | o_flags.bus_perm_recessive_flag | o_flags.rx_line_recessive_flag;
	wire logic rdy = o_state == ctmc_pkg::CTMC_READY;
	wire logic slp = o_state == ctmc_pkg::CTMC_SLEEP;
	// one cycle of slack: flag and enable are both registered
	chk_tx_blocked: assert property (blk ##1 blk |-> !o_tx_enabled)
		else $error("transmitter on while blocked");
	chk_tx_low_power: assert property (!rdy |-> !o_tx_enabled)
		else $error("transmitter on outside ready");
	chk_bias_ready: assert property (rdy ##1 rdy |-> o_bias_on)
		else $error("bias off in ready");
	chk_sleep_unbiased: assert property (slp ##1 slp |-> !o_bias_on)
		else $error("bias on in sleep");
	chk_irq_single: assert property (o_wake_irq |=> !o_wake_irq)
		else $error("wake pulse too long");
	// pulse and new state land on the same edge
	chk_wake_target: assert property (o_wake_irq && $past(slp) |->
		o_state == ($past(i_ctrl.pretended_network_enable) ? ctmc_pkg::CTMC_BIAS : ctmc_pkg::CTMC_READY))
		else $error("wrong state after sleep wake");
	chk_bias_wake: assert property (o_wake_irq && $past(o_state == ctmc_pkg::CTMC_BIAS) &&
		$past(i_ctrl.low_power_mode_ok) |-> rdy)
		else $error("no ready after bias wake");
	chk_loop_route: assert property (i_ctrl.loopback_enable && $fell(i_txd) ##1
		(i_ctrl.loopback_enable && !i_txd)[*4] |-> !o_rxd && o_bus_tx)
		else $error("loopback not routed");
	chk_rx_kept: assert property (o_rx_enabled && $rose(blk) && $stable(i_ctrl) |=> o_rx_enabled)
		else $error("receiver dropped on failure");
endmodule
bind ctmc_top ctmc_chk u_chk (.i_clock(i_clock), .i_nrst(i_nrst), .i_ctrl(i_ctrl), .i_txd(i_txd), .o_rxd(o_rxd),
	.o_bus_tx(o_bus_tx), .o_tx_enabled(o_tx_enabled), .o_rx_enabled(o_rx_enabled), .o_bias_on(o_bias_on),
	.o_wake_irq(o_wake_irq), .o_state(o_state), .o_flags(o_flags));
`default_nettype wire

// ### ctmc_mcu_model.sv
`default_nettype none
// ****************************************
// host controller transmit line
// ****************************************
module ctmc_mcu_model (
	input wire logic i_clock,
	output var logic o_txd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_txd = 1'b1;
	// level held whole cycles, returns once outputs have settled
	task automatic send_bit(input logic b, input int n);
		@(posedge i_clock);
		o_txd <= b;
		repeat (n) @(posedge i_clock);
		#1;
	endtask
endmodule
`default_nettype wire

// ### ctmc_top_tb.sv
`default_nettype none
module ctmc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DOMT = 40;
	localparam int SIL  = 60;
	localparam int PDOM = 80;
	logic                  clk, nrst, tsd, ext_bus, stuck_rec, b;
	logic [5:0]            modes [3] = '{6'h03, 6'h13, 6'h33};
	int                    errors, num_checks;
	ctmc_pkg::ctmc_ctrl_t  ctrl;
	ctmc_pkg::ctmc_flags_t clr, flags;
	ctmc_pkg::ctmc_state_t st;
	wire logic             txd, rxd, bus_tx, tx_en, rx_en, bias, irq;
	// bus is wired-and, pulled recessive; stuck_rec models an open bus
	wire logic             bus_rx = stuck_rec | (bus_tx & ext_bus);

	ctmc_top #(.DOM_TIMEOUT(DOMT), .SILENCE(SIL), .BIAS_ACT(50), .PERM_DOM(PDOM)) dut (.i_clock(clk), .i_nrst(nrst),
		.i_ctrl(ctrl), .i_flag_clear(clr), .i_thermal_shutdown_level_one(tsd), .i_txd(txd), .i_bus_rx(bus_rx),
		.o_rxd(rxd), .o_bus_tx(bus_tx), .o_tx_enabled(tx_en), .o_rx_enabled(rx_en), .o_bias_on(bias),
		.o_wake_irq(irq), .o_state(st), .o_flags(flags));
	ctmc_mcu_model mcu (.i_clock(clk), .o_txd(txd));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic set_ctrl(input logic [5:0] v);
		@(posedge clk);
		ctrl <= v;
		cyc(4);
	endtask
	task automatic drive_bus(input logic v, input int n);
		@(posedge clk);
		ext_bus <= v;
		cyc(n);
	endtask
	task automatic clear();
		@(posedge clk);
		clr <= '1;
		@(posedge clk);
		clr <= '0;
		cyc(4);
	endtask
	task automatic rst();
		@(posedge clk);
		nrst <= 1'b0;
		cyc(3);
		@(posedge clk);
		nrst <= 1'b1;
		cyc(5);
	endtask
	// dominant, recessive, dominant held until the pulse shows
	task automatic wake();
		int n;
		drive_bus(1'b0, 8);
		drive_bus(1'b1, 8);
		drive_bus(1'b0, 0);
		n = 0;
		while (irq !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk(irq, 1'b1);
		if (n == 40) begin
			end_sim();
		end
		drive_bus(1'b1, 3);
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h7051_f28c));
		errors = 0;
		num_checks = 0;
		{nrst, tsd, stuck_rec, ext_bus, ctrl, clr} = '0;
		rst();
		chk(st, ctmc_pkg::CTMC_SLEEP);
		chk({bias, tx_en, rx_en, rxd, bus_tx}, 5'h03);
		set_ctrl(6'h18);
		wake();
		chk(st, ctmc_pkg::CTMC_BIAS);
		chk({bias, tx_en, rx_en}, 3'h4);
		repeat (4) begin
			b = 1'($urandom);
			drive_bus(b, 6);
			chk(rxd, b);
		end
		drive_bus(1'b1, SIL + 10);
		chk({st, bias}, {ctmc_pkg::CTMC_SLEEP, 1'b0});
		wake();
		chk(st, ctmc_pkg::CTMC_BIAS);
		set_ctrl(6'h19);
		wake();
		chk(st, ctmc_pkg::CTMC_READY);
		rst();
		set_ctrl(6'h01);
		wake();
		chk(st, ctmc_pkg::CTMC_READY);
		foreach (modes[i]) begin
			set_ctrl(modes[i]);
			chk({bias, tx_en, rx_en}, {1'b1, modes[i][5:4]});
		end
		repeat (6) begin
			b = 1'($urandom);
			mcu.send_bit(b, 6);
			chk({bus_tx, rxd}, {b, b});
		end
		mcu.send_bit(1'b1, 4);
		drive_bus(1'b0, PDOM + 10);
		chk({flags.bus_perm_dominant_flag, tx_en}, 2'h3);
		drive_bus(1'b1, 2);
		clear();
		chk(flags, ctmc_pkg::FLAGS_RESET);
		mcu.send_bit(1'b0, DOMT + 10);
		chk({flags.txd_dom_flag, tx_en, rx_en}, 3'h5);
		mcu.send_bit(1'b1, 5);
		chk(tx_en, 1'b0);
		clear();
		chk(tx_en, 1'b1);
		@(posedge clk);
		stuck_rec <= 1'b1;
		repeat (3) begin
			mcu.send_bit(1'b0, 15);
			mcu.send_bit(1'b1, 15);
		end
		chk({flags.bus_perm_recessive_flag, flags.rx_line_recessive_flag}, 2'h0);
		mcu.send_bit(1'b0, 15);
		mcu.send_bit(1'b1, 5);
		chk({flags.bus_perm_recessive_flag, flags.rx_line_recessive_flag, tx_en, rx_en}, 4'hd);
		@(posedge clk);
		stuck_rec <= 1'b0;
		clear();
		chk(tx_en, 1'b1);
		@(posedge clk);
		tsd <= 1'b1;
		cyc(5);
		chk({tx_en, rx_en}, 2'h1);
		@(posedge clk);
		tsd <= 1'b0;
		cyc(5);
		chk(tx_en, 1'b1);
		set_ctrl(6'h37);
		repeat (6) begin
			b = 1'($urandom);
			mcu.send_bit(b, 6);
			chk({bus_tx, rxd}, {1'b1, b});
		end
		end_sim();
	end
endmodule
`default_nettype wire
